// ### hw/otp_cfg_trim_area.sv
// Configuration and trim storage with link command core and mirror registers
//
// How it works
// - Four 32-byte byte-addressed regions at 0x00, 0x20, 0x40 and 0x60.
// - Programming a user byte can only turn bits from 0 to 1.
// - User region erase leaves every bit at 0, the blank value.
// - Blank test passes only when all user bytes read 0x00.
// - One program step ORs a whole byte value into the cell.
// - All four regions are readable over the link.
// - Config bit 7 enables the external reset pin; 0 disables it.
// - Lock size bits 3:2 pick end 7DFh, 7BFh, 77Fh or 6FFh.
// - Config bit 1 enables hard write protection of that code range.
// - Config bit 0 enables code read protection.
// - Config and five trim bytes mirror into registers F8h to FDh.
// - Link query reports whether code read protection is active.
// - All programmer access runs over the two-wire debug link, data plus clock; the core reads the mirror registers directly.
`timescale 1ns/1ps
`default_nettype none
module otp_cfg_trim_area #(
   parameter int unsigned DEPTH = otp_pkg::OTP_DEPTH,
   parameter int unsigned USER_BYTES = otp_pkg::REGION_BYTES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_link_clk,
   input wire logic i_link_data,
   output logic o_link_data,
   output logic o_link_data_oe,
   input wire logic i_factory_mode,
   input wire logic [7:0] i_sfr_addr,
   output logic [7:0] o_sfr_rdata,
   output logic o_reset_pin_enable,
   output logic o_write_protect_enable,
   output logic [1:0] o_hard_lock_size,
   output logic [10:0] o_lock_end,
   output logic o_read_protect_enable,
   output logic [7:0] o_osc_calibration_value,
   input wire logic [10:0] i_code_wr_addr,
   output logic o_code_wr_block,
   output logic [10:0] o_code_rd_addr,
   input wire logic [7:0] i_code_rd_data,
   output logic o_mirror_ready
);
   import otp_pkg::*;

   typedef struct packed {
      core_state_e state;
      logic [2:0] load_idx;
      logic [MIRROR_COUNT-1:0][7:0] mirror;
      logic entered;
      logic erase;
      logic prog;
      logic [6:0] prog_addr;
      logic [7:0] prog_data;
      logic resp_valid;
      logic [7:0] resp_data;
      logic [10:0] code_addr;
      logic [7:0] sfr_rdata;
      logic [10:0] lock_end;
   } core_s;

   core_s st;
   core_s next_st;
   link_frame_if frame ();

   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   logic user_blank;
   logic [6:0] load_addr;
   logic [7:0] user_cfg;
   logic in_range;
   logic in_user;

   // All programmer traffic arrives through this shifter
   two_wire_phy u_phy (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_link_clk(i_link_clk),
      .i_link_data(i_link_data),
      .o_link_data(o_link_data),
      .o_link_data_oe(o_link_data_oe),
      .frame(frame)
   );

   otp_store #(
      .DEPTH(DEPTH),
      .USER_BYTES(USER_BYTES)
   ) u_store (
      .i_clk(i_clk),
      .i_erase_user(st.erase),
      .i_prog(st.prog),
      .i_prog_addr(st.prog_addr),
      .i_prog_data(st.prog_data),
      .i_rd_addr(rd_addr),
      .o_rd_data(rd_data),
      .o_user_blank(user_blank)
   );

   // Source addresses of the mirror bytes, walked once after reset
   always_comb begin
      unique case (st.load_idx)
         3'd0: begin
            load_addr = OTP_USER_CONFIG;
         end
         3'd1: begin
            load_addr = OTP_OSC_CAL;
         end
         3'd2: begin
            load_addr = OTP_VOLT_DET;
         end
         3'd3: begin
            load_addr = OTP_SUPPLY_WDT;
         end
         3'd4: begin
            load_addr = OTP_REFERENCE;
         end
         default: begin
            load_addr = OTP_SPARE;
         end
      endcase
   end

   // Byte addresses 00h..7Fh span all four regions
   assign in_range = (frame.addr[7] == 1'b0);
   assign in_user = (frame.addr[6:0] < REGION_B_BASE);

   // The mirror walk owns the read port until it is done
   always_comb begin
      if (st.state == ST_LOAD) begin
         rd_addr = load_addr;
      end else begin
         rd_addr = frame.addr[6:0];
      end
   end

   // Mirror copy only: a fresh program step does not change behaviour
   // until the next reset reloads it
   assign user_cfg = st.mirror[0];

   always_comb begin
      next_st = st;
      next_st.erase = 1'b0;
      next_st.prog = 1'b0;
      next_st.resp_valid = 1'b0;
      unique case (st.state)
         ST_LOAD: begin
            next_st.mirror[st.load_idx] = rd_data;
            if (st.load_idx == 3'(MIRROR_COUNT - 1)) begin
               next_st.state = ST_IDLE;
            end else begin
               next_st.load_idx = st.load_idx + 3'd1;
            end
         end
         ST_IDLE: begin
            if (frame.frame_valid && !frame.busy) begin
               if (frame.cmd == CMD_ENTRY) begin
                  next_st.entered = (frame.data == ENTRY_KEY);
                  next_st.resp_valid = 1'b1;
                  next_st.resp_data = (frame.data == ENTRY_KEY) ? STAT_OK : STAT_FAIL;
               end else if (st.entered) begin
                  next_st.resp_valid = 1'b1;
                  next_st.resp_data = STAT_FAIL;
                  unique case (frame.cmd)
                     CMD_ERASE_A: begin
                        // Only the user region has an erase; factory regions
                        // keep their calibration
                        next_st.erase = 1'b1;
                        next_st.resp_data = STAT_OK;
                     end
                     CMD_BLANK_TEST: begin
                        next_st.resp_data = user_blank ? STAT_OK : STAT_FAIL;
                     end
                     CMD_PROGRAM: begin
                        // Factory regions accept programming only in factory mode
                        if (in_range && (in_user || i_factory_mode)) begin
                           next_st.prog = 1'b1;
                           next_st.prog_addr = frame.addr[6:0];
                           next_st.prog_data = frame.data;
                           next_st.resp_data = STAT_OK;
                        end
                     end
                     CMD_READ: begin
                        if (in_range) begin
                           next_st.resp_data = rd_data;
                        end
                     end
                     CMD_LOCK_QUERY: begin
                        next_st.resp_data = {7'd0, user_cfg[CFG_READ_PROT_BIT]};
                     end
                     CMD_TRIM_REPORT: begin
                        // Mirror index in the address byte; out of range reads zero
                        if (frame.addr < 8'(MIRROR_COUNT)) begin
                           next_st.resp_data = st.mirror[frame.addr[2:0]];
                        end
                     end
                     CMD_CODE_READ: begin
                        // Give the code memory one cycle to answer
                        next_st.resp_valid = 1'b0;
                        next_st.code_addr = {frame.data[2:0], frame.addr};
                        next_st.state = ST_CODE;
                     end
                     default: begin
                        next_st.resp_data = STAT_FAIL;
                     end
                  endcase
               end
            end
         end
         ST_CODE: begin
            next_st.resp_valid = 1'b1;
            if (user_cfg[CFG_READ_PROT_BIT]) begin
               next_st.resp_data = CODE_HIDDEN;
            end else begin
               next_st.resp_data = i_code_rd_data;
            end
            next_st.state = ST_IDLE;
         end
         default: begin
            next_st.state = ST_IDLE;
         end
      endcase
      // Mirror registers seen by the core at F8h..FDh
      unique case (i_sfr_addr)
         SFR_USER_CONFIG: begin
            next_st.sfr_rdata = st.mirror[0];
         end
         SFR_OSC_CAL: begin
            next_st.sfr_rdata = st.mirror[1];
         end
         SFR_VOLT_DET: begin
            next_st.sfr_rdata = st.mirror[2];
         end
         SFR_SUPPLY_WDT: begin
            next_st.sfr_rdata = st.mirror[3];
         end
         SFR_REFERENCE: begin
            next_st.sfr_rdata = st.mirror[4];
         end
         SFR_SPARE: begin
            next_st.sfr_rdata = st.mirror[5];
         end
         default: begin
            next_st.sfr_rdata = 8'h00;
         end
      endcase
      // Decoded from the mirror value about to be stored, so the end
      // address register never lags the lock size bits
      unique case (next_st.mirror[0][CFG_LOCK_SIZE_LSB +: 2])
         2'b00: begin
            next_st.lock_end = LOCK_END_0;
         end
         2'b01: begin
            next_st.lock_end = LOCK_END_1;
         end
         2'b10: begin
            next_st.lock_end = LOCK_END_2;
         end
         2'b11: begin
            next_st.lock_end = LOCK_END_3;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st.state <= ST_LOAD;
         st.load_idx <= 3'd0;
         st.mirror <= {MIRROR_COUNT{MIRROR_RESET}};
         st.entered <= 1'b0;
         st.erase <= 1'b0;
         st.prog <= 1'b0;
         st.prog_addr <= 7'd0;
         st.prog_data <= 8'h00;
         st.resp_valid <= 1'b0;
         st.resp_data <= 8'h00;
         st.code_addr <= 11'd0;
         st.sfr_rdata <= 8'h00;
         st.lock_end <= LOCK_END_0;
      end else begin
         st <= next_st;
      end
   end

   assign frame.resp_valid = st.resp_valid;
   assign frame.resp_data = st.resp_data;

   assign o_sfr_rdata = st.sfr_rdata;
   assign o_reset_pin_enable = user_cfg[CFG_RESET_PIN_BIT];
   assign o_write_protect_enable = user_cfg[CFG_WRITE_PROT_BIT];
   assign o_hard_lock_size = user_cfg[CFG_LOCK_SIZE_LSB +: 2];
   assign o_lock_end = st.lock_end;
   assign o_read_protect_enable = user_cfg[CFG_READ_PROT_BIT];
   assign o_osc_calibration_value = st.mirror[1];
   assign o_code_wr_block = user_cfg[CFG_WRITE_PROT_BIT]
      && (i_code_wr_addr <= st.lock_end);
   assign o_code_rd_addr = st.code_addr;
   assign o_mirror_ready = (st.state != ST_LOAD);
endmodule
`default_nettype wire

// ### hw/otp_pkg.sv
// Shared constants for the configuration and trim storage block
package otp_pkg;
   localparam int unsigned OTP_DEPTH = 128;
   localparam int unsigned REGION_BYTES = 32;
   localparam logic [6:0] REGION_A_BASE = 7'h00;
   localparam logic [6:0] REGION_B_BASE = 7'h20;
   localparam logic [6:0] REGION_C_BASE = 7'h40;
   localparam logic [6:0] REGION_D_BASE = 7'h60;
   localparam logic [6:0] REGION_LAST = 7'h7f;
   localparam logic [7:0] BLANK_VALUE = 8'h00;
   // Mirror register addresses in the special-function space
   localparam logic [7:0] SFR_USER_CONFIG = 8'hf8;
   localparam logic [7:0] SFR_OSC_CAL = 8'hf9;
   localparam logic [7:0] SFR_VOLT_DET = 8'hfa;
   localparam logic [7:0] SFR_SUPPLY_WDT = 8'hfb;
   localparam logic [7:0] SFR_REFERENCE = 8'hfc;
   localparam logic [7:0] SFR_SPARE = 8'hfd;
   localparam int unsigned MIRROR_COUNT = 6;
   // Source byte of each mirror register inside the storage
   localparam logic [6:0] OTP_USER_CONFIG = 7'h00;
   localparam logic [6:0] OTP_OSC_CAL = 7'h20;
   localparam logic [6:0] OTP_VOLT_DET = 7'h40;
   localparam logic [6:0] OTP_SUPPLY_WDT = 7'h41;
   localparam logic [6:0] OTP_REFERENCE = 7'h42;
   localparam logic [6:0] OTP_SPARE = 7'h43;
   // User configuration byte fields
   localparam int unsigned CFG_RESET_PIN_BIT = 7;
   localparam int unsigned CFG_LOCK_SIZE_LSB = 2;
   localparam int unsigned CFG_WRITE_PROT_BIT = 1;
   localparam int unsigned CFG_READ_PROT_BIT = 0;
   localparam logic [7:0] MIRROR_RESET = 8'h00;
   // Last protected code address per lock size code
   localparam logic [10:0] LOCK_END_0 = 11'h7df;
   localparam logic [10:0] LOCK_END_1 = 11'h7bf;
   localparam logic [10:0] LOCK_END_2 = 11'h77f;
   localparam logic [10:0] LOCK_END_3 = 11'h6ff;
   // Link frame layout and command codes
   localparam int unsigned FRAME_BITS = 24;
   localparam int unsigned RESP_BITS = 8;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [7:0] CMD_ENTRY = 8'h01;
   localparam logic [7:0] CMD_ERASE_A = 8'h02;
   localparam logic [7:0] CMD_BLANK_TEST = 8'h03;
   localparam logic [7:0] CMD_PROGRAM = 8'h04;
   localparam logic [7:0] CMD_READ = 8'h05;
   localparam logic [7:0] CMD_LOCK_QUERY = 8'h06;
   localparam logic [7:0] CMD_TRIM_REPORT = 8'h07;
   localparam logic [7:0] CMD_CODE_READ = 8'h08;
   localparam logic [7:0] ENTRY_KEY = 8'h5a;
   localparam logic [7:0] STAT_OK = 8'h01;
   localparam logic [7:0] STAT_FAIL = 8'h00;
   localparam logic [7:0] CODE_HIDDEN = 8'h00;
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_IDLE = 2'b01,
      ST_CODE = 2'b11
   } core_state_e;
endpackage

// ### hw/link_frame_if.sv
// Frame and response handshake between the link shifter and the core
`timescale 1ns/1ps
`default_nettype none
interface link_frame_if;
   logic frame_valid;
   logic [7:0] cmd;
   logic [7:0] addr;
   logic [7:0] data;
   logic resp_valid;
   logic [7:0] resp_data;
   logic busy;
   modport phy (output frame_valid, output cmd, output addr, output data, output busy,
      input resp_valid, input resp_data);
   modport core (input frame_valid, input cmd, input addr, input data, input busy,
      output resp_valid, output resp_data);
endinterface
`default_nettype wire

// ### hw/two_wire_phy.sv
// Two-wire debug link shifter: pin synchronisers, frame receive, byte reply
`timescale 1ns/1ps
`default_nettype none
module two_wire_phy (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_link_clk,
   input wire logic i_link_data,
   output logic o_link_data,
   output logic o_link_data_oe,
   link_frame_if.phy frame
);
   import otp_pkg::*;
   typedef struct packed {
      logic [SYNC_STAGES-1:0] clk_s;
      logic [SYNC_STAGES-1:0] dat_s;
      logic clk_f;
      logic dat_f;
      logic [FRAME_BITS-1:0] rx_sh;
      logic [4:0] rx_cnt;
      logic [7:0] tx_sh;
      logic [2:0] tx_cnt;
      logic oe;
      logic valid;
   } phy_s;
   phy_s st;
   phy_s next_st;
   logic rise;

   always_comb begin
      next_st = st;
      next_st.valid = 1'b0;
      next_st.clk_s = {st.clk_s[1:0], i_link_clk};
      next_st.dat_s = {st.dat_s[1:0], i_link_data};
      // A level counts only once the second and third stages agree
      if (st.clk_s[1] == st.clk_s[2]) begin
         next_st.clk_f = st.clk_s[2];
      end
      if (st.dat_s[1] == st.dat_s[2]) begin
         next_st.dat_f = st.dat_s[2];
      end
      rise = !st.clk_f && (st.clk_s[1] == st.clk_s[2]) && st.clk_s[2];
      if (frame.resp_valid && !st.oe) begin
         next_st.tx_sh = frame.resp_data;
         next_st.tx_cnt = 3'd7;
         next_st.oe = 1'b1;
      end else if (rise && st.oe) begin
         // Host sampled the current bit on this edge; move to the next one
         next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
         next_st.tx_cnt = st.tx_cnt - 3'd1;
         if (st.tx_cnt == 3'd0) begin
            next_st.oe = 1'b0;
         end
      end else if (rise) begin
         next_st.rx_sh = {st.rx_sh[FRAME_BITS-2:0], st.dat_f};
         if (st.rx_cnt == 5'(FRAME_BITS - 1)) begin
            next_st.rx_cnt = 5'd0;
            next_st.valid = 1'b1;
         end else begin
            next_st.rx_cnt = st.rx_cnt + 5'd1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign frame.frame_valid = st.valid;
   assign frame.cmd = st.rx_sh[23:16];
   assign frame.addr = st.rx_sh[15:8];
   assign frame.data = st.rx_sh[7:0];
   assign frame.busy = st.oe;
   assign o_link_data = st.tx_sh[7];
   assign o_link_data_oe = st.oe;
endmodule
`default_nettype wire

// ### hw/otp_store.sv
// One-time-programmable byte storage of the four configuration regions
`timescale 1ns/1ps
`default_nettype none
module otp_store #(
   parameter int unsigned DEPTH = 128,
   parameter int unsigned USER_BYTES = 32
) (
   input wire logic i_clk,
   input wire logic i_erase_user,
   input wire logic i_prog,
   input wire logic [6:0] i_prog_addr,
   input wire logic [7:0] i_prog_data,
   input wire logic [6:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   output logic o_user_blank
);
   import otp_pkg::*;
   // Storage is nonvolatile, so the system reset does not touch it
   logic [7:0] mem [DEPTH] = '{default: BLANK_VALUE};
   logic [7:0] next_mem [DEPTH];
   logic [USER_BYTES-1:0] byte_blank;

   always_comb begin
      next_mem = mem;
      if (i_erase_user) begin
         for (int i = 0; i < USER_BYTES; i++) begin
            next_mem[i] = BLANK_VALUE;
         end
      end else if (i_prog) begin
         // Bits can only rise; a zero in the value leaves the cell alone
         next_mem[i_prog_addr] = mem[i_prog_addr] | i_prog_data;
      end
   end

   always_ff @(posedge i_clk) begin
      mem <= next_mem;
   end

   for (genvar g = 0; g < USER_BYTES; g++) begin : g_blank
      assign byte_blank[g] = (mem[g] == BLANK_VALUE);
   end

   assign o_user_blank = &byte_blank;
   assign o_rd_data = mem[i_rd_addr];
endmodule
`default_nettype wire

// ### sim/otp_cfg_trim_area_properties.sv
// Port-level assertions for the configuration and trim storage block
`timescale 1ns/1ps
`default_nettype none
module otp_cfg_trim_area_properties
   import otp_pkg::*;
#(
   parameter int unsigned DEPTH = 128,
   parameter int unsigned USER_BYTES = 32
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_link_clk,
   input wire logic o_link_data_oe,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic o_reset_pin_enable,
   input wire logic o_write_protect_enable,
   input wire logic [1:0] o_hard_lock_size,
   input wire logic [10:0] o_lock_end,
   input wire logic o_read_protect_enable,
   input wire logic [7:0] o_osc_calibration_value,
   input wire logic [10:0] i_code_wr_addr,
   input wire logic o_code_wr_block,
   input wire logic o_mirror_ready
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic lk_q;
   logic [3:0] rise_cnt;
   // Raw link clock rises seen while the reply is being driven
   always_ff @(posedge i_clk) begin
      lk_q <= i_link_clk;
      if (i_sys_rst || !o_link_data_oe) begin
         rise_cnt <= 4'h0;
      end else if (i_link_clk && !lk_q) begin
         rise_cnt <= rise_cnt + 4'h1;
      end
   end
   property p_lock_end;
      o_lock_end == (o_hard_lock_size == 2'b00 ? LOCK_END_0 : o_hard_lock_size == 2'b01 ?
         LOCK_END_1 : o_hard_lock_size == 2'b10 ? LOCK_END_2 : LOCK_END_3);
   endproperty
   a_lock_end: assert property (p_lock_end) else $error("lock end mismatch");
   property p_wr_block;
      o_code_wr_block == (o_write_protect_enable && (i_code_wr_addr <= o_lock_end));
   endproperty
   a_wr_block: assert property (p_wr_block) else $error("write block mismatch");
   property p_sfr_cfg;
      (i_sfr_addr == SFR_USER_CONFIG && o_mirror_ready) |=> o_sfr_rdata[7] == o_reset_pin_enable
         && o_sfr_rdata[3:0] == {o_hard_lock_size, o_write_protect_enable, o_read_protect_enable};
   endproperty
   a_sfr_cfg: assert property (p_sfr_cfg) else $error("config mirror mismatch");
   property p_sfr_osc;
      (i_sfr_addr == SFR_OSC_CAL && o_mirror_ready) |=> o_sfr_rdata == o_osc_calibration_value;
   endproperty
   a_sfr_osc: assert property (p_sfr_osc) else $error("oscillator mirror mismatch");
   property p_sfr_none;
      (i_sfr_addr < SFR_USER_CONFIG || i_sfr_addr > SFR_SPARE) |=> o_sfr_rdata == 8'h00;
   endproperty
   a_sfr_none: assert property (p_sfr_none) else $error("unmapped mirror not zero");
   property p_mirror_hold;
      o_mirror_ready |=> $stable({o_reset_pin_enable, o_hard_lock_size, o_write_protect_enable,
         o_read_protect_enable, o_osc_calibration_value});
   endproperty
   a_mirror_hold: assert property (p_mirror_hold) else $error("mirror changed");
   property p_reload;
      $fell(i_sys_rst) |-> !o_mirror_ready [*5] ##[1:2] o_mirror_ready;
   endproperty
   a_reload: assert property (p_reload) else $error("mirror reload timing");
   property p_reply_len;
      $fell(o_link_data_oe) |-> rise_cnt == 4'h8;
   endproperty
   a_reply_len: assert property (p_reply_len) else $error("reply not 8 clocks");
   c_ready: cover property ($rose(o_mirror_ready));
   c_block: cover property (o_code_wr_block);
   c_reply: cover property ($fell(o_link_data_oe));
endmodule
bind otp_cfg_trim_area otp_cfg_trim_area_properties #(.DEPTH(DEPTH), .USER_BYTES(USER_BYTES))
   u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
   .o_link_data_oe(o_link_data_oe), .i_sfr_addr(i_sfr_addr), .o_sfr_rdata(o_sfr_rdata),
   .o_reset_pin_enable(o_reset_pin_enable), .o_write_protect_enable(o_write_protect_enable),
   .o_hard_lock_size(o_hard_lock_size), .o_lock_end(o_lock_end),
   .o_read_protect_enable(o_read_protect_enable),
   .o_osc_calibration_value(o_osc_calibration_value), .i_code_wr_addr(i_code_wr_addr),
   .o_code_wr_block(o_code_wr_block), .o_mirror_ready(o_mirror_ready));
`default_nettype wire

// ### sim/link_programmer.sv
// Behavioural production programmer on the far side of the two-wire link
`timescale 1ns/1ps
`default_nettype none
module link_programmer #(
   parameter int HALF = 4,
   parameter int GAP = 12
) (
   input wire logic i_clk,
   output logic o_link_clk,
   output logic o_link_data,
   input wire logic i_link_wire
);
   initial begin
      o_link_clk = 1'b0;
      o_link_data = 1'b0;
   end
   // Line is sampled just before the rising edge, while the reply bit still stands
   task automatic bit_cycle(input logic d, output logic s);
      o_link_data = d;
      repeat (HALF) @(negedge i_clk);
      s = i_link_wire;
      o_link_clk = 1'b1;
      repeat (HALF) @(negedge i_clk);
      o_link_clk = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
      input logic rep, output logic [7:0] r);
      logic [23:0] f;
      logic s;
      f = {c, a, d};
      r = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         bit_cycle(f[i], s);
      end
      // Released line shows the inverse so a stale bit never passes for a reply
      o_link_data = ~o_link_data;
      if (rep) begin
         repeat (GAP) @(negedge i_clk);
         for (int i = 7; i >= 0; i--) begin
            bit_cycle(~o_link_data, r[i]);
         end
      end
   endtask
endmodule
`default_nettype wire

// ### sim/tb_otp_cfg_trim_area.sv
// Self-checking bench: link commands, mirror registers and protection outputs
`timescale 1ns/1ps
`default_nettype none
module tb_otp_cfg_trim_area;
   import otp_pkg::*;
   logic clk, rst, lclk, hdata, fmode, dev_d, dev_oe, oe_seen, rpe, wpe, rde, wblk, rdy;
   logic [7:0] sfr_addr, sfr_rdata, code_rd, osc, r;
   logic [10:0] wr_addr, lend, rd_addr;
   logic [1:0] lsz;
   int fail_count, n_checks;
   logic [7:0] sfr_exp [0:7] = '{8'h00, 8'h8f, 8'ha5, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [10:0] lock_tab [0:3] = '{LOCK_END_0, LOCK_END_1, LOCK_END_2, LOCK_END_3};
   wire line = dev_oe ? dev_d : hdata;
   otp_cfg_trim_area #(.DEPTH(128), .USER_BYTES(32)) DUT (
      .i_clk(clk), .i_sys_rst(rst), .i_link_clk(lclk), .i_link_data(line),
      .o_link_data(dev_d), .o_link_data_oe(dev_oe), .i_factory_mode(fmode),
      .i_sfr_addr(sfr_addr), .o_sfr_rdata(sfr_rdata), .o_reset_pin_enable(rpe),
      .o_write_protect_enable(wpe), .o_hard_lock_size(lsz), .o_lock_end(lend),
      .o_read_protect_enable(rde), .o_osc_calibration_value(osc),
      .i_code_wr_addr(wr_addr), .o_code_wr_block(wblk), .o_code_rd_addr(rd_addr),
      .i_code_rd_data(code_rd), .o_mirror_ready(rdy));
   link_programmer #(.HALF(4), .GAP(12)) prog (.i_clk(clk), .o_link_clk(lclk),
      .o_link_data(hdata), .i_link_wire(line));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (dev_oe) oe_seen <= 1'b1;
   // Code memory stand-in: a byte derived from the requested address
   always @(negedge clk) code_rd <= rd_addr[7:0] ^ 8'h3c;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] exp);
      prog.xfer(c, a, d, 1'b1, r);
      check(r, exp);
   endtask
   task automatic silent(input logic [7:0] c);
      oe_seen = 1'b0;
      prog.xfer(c, 8'h00, 8'h00, 1'b0, r);
      repeat (12) @(negedge clk);
      check(oe_seen, 1'b0);
   endtask
   task automatic do_reset;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (10) @(negedge clk);
      check(rdy, 1'b1);
   endtask
   task automatic sfr(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      @(negedge clk);
      check(sfr_rdata, e);
   endtask
   task automatic wblk_at(input logic [10:0] a, input logic e);
      wr_addr = a;
      @(negedge clk);
      check(wblk, e);
   endtask
   task automatic test_done;
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      fail_count++;
      test_done;
   end
   initial begin
      fail_count = 0;
      n_checks = 0;
      oe_seen = 1'b0;
      fmode = 1'b0;
      sfr_addr = 8'h00;
      wr_addr = 11'h000;
      code_rd = 8'h00;
      do_reset;
      silent(CMD_READ);
      op(CMD_ENTRY, 8'h00, 8'h33, STAT_FAIL);
      silent(CMD_LOCK_QUERY);
      op(CMD_ENTRY, 8'h00, ENTRY_KEY, STAT_OK);
      op(CMD_ERASE_A, 8'h00, 8'h00, STAT_OK);
      op(CMD_BLANK_TEST, 8'h00, 8'h00, STAT_OK);
      for (int i = 0; i < 4; i++) begin
         op(CMD_READ, 8'(i * 32), 8'h00, BLANK_VALUE);
         op(CMD_READ, 8'(i * 32 + 31), 8'h00, BLANK_VALUE);
      end
      op(CMD_PROGRAM, 8'h00, 8'h81, STAT_OK);
      op(CMD_READ, 8'h00, 8'h00, 8'h81);
      op(CMD_BLANK_TEST, 8'h00, 8'h00, STAT_FAIL);
      op(CMD_PROGRAM, 8'h00, 8'h02, STAT_OK);
      op(CMD_READ, 8'h00, 8'h00, 8'h83);
      op(CMD_PROGRAM, 8'h1f, 8'h10, STAT_OK);
      check(rpe, 1'b0);
      op(CMD_PROGRAM, 8'h20, 8'ha5, STAT_FAIL);
      fmode = 1'b1;
      op(CMD_PROGRAM, 8'h20, 8'ha5, STAT_OK);
      op(CMD_PROGRAM, 8'h40, 8'h3c, STAT_OK);
      fmode = 1'b0;
      op(CMD_ERASE_A, 8'h00, 8'h00, STAT_OK);
      op(CMD_READ, 8'h1f, 8'h00, BLANK_VALUE);
      op(CMD_READ, 8'h00, 8'h00, BLANK_VALUE);
      op(CMD_READ, 8'h20, 8'h00, 8'ha5);
      op(CMD_BLANK_TEST, 8'h00, 8'h00, STAT_OK);
      op(CMD_PROGRAM, 8'h00, 8'h8f, STAT_OK);
      op(CMD_READ, 8'h00, 8'h00, 8'h8f);
      do_reset;
      op(CMD_ENTRY, 8'h00, ENTRY_KEY, STAT_OK);
      check({rpe, lsz, wpe, rde}, 5'h1f);
      check(osc, 8'ha5);
      for (int i = 0; i < 8; i++) sfr(8'hf7 + 8'(i), sfr_exp[i]);
      op(CMD_LOCK_QUERY, 8'h00, 8'h00, 8'h01);
      op(CMD_TRIM_REPORT, 8'h01, 8'h00, 8'ha5);
      op(CMD_CODE_READ, 8'h12, 8'h01, CODE_HIDDEN);
      op(8'h09, 8'h00, 8'h00, STAT_FAIL);
      for (int k = 0; k < 4; k++) begin
         op(CMD_ERASE_A, 8'h00, 8'h00, STAT_OK);
         op(CMD_PROGRAM, 8'h00, {4'h0, 2'(k), 2'b10}, STAT_OK);
         do_reset;
         op(CMD_ENTRY, 8'h00, ENTRY_KEY, STAT_OK);
         check({rpe, lsz, wpe, rde}, {1'b0, 2'(k), 2'b10});
         check(lend, lock_tab[k]);
         wblk_at(lock_tab[k], 1'b1);
         wblk_at(lock_tab[k] + 11'h001, 1'b0);
         op(CMD_LOCK_QUERY, 8'h00, 8'h00, 8'h00);
         op(CMD_CODE_READ, 8'h12, 8'h01, 8'h2e);
      end
      test_done;
   end
endmodule
`default_nettype wire
